//--- dv/tb_tmrpw_top.sv
`timescale 1ns/10ps

module tb_tmrpw_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic timer_in_pin = 1'b0;
  logic comparator_out = 1'b0;
  tmrpw_pkg::tmrpw_pins_t timer_pins;
  logic irq;
  logic [64:0] exp_q[$];
  logic [64:0] e;
  logic [15:0] ra[5] = '{16'h3C08, 16'h3C0C, 16'h3C10, 16'h3C14, 16'h3C18};
  logic [7:0] rv[5] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};
  logic [7:0] wv[5];
  logic [1:0] seen;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;

  tmrpw_top u_tmrpw_top (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_in_pin(timer_in_pin), .comparator_out(comparator_out),
    .timer_pins(timer_pins), .irq(irq));

  always #12.5 mclk = ~mclk;

  task automatic tally_and_finish;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    checked++;
    if (got !== want) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h want=%h", $time, got, want);
    end
  endtask

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic [15:0] a, input logic w, input logic [31:0] d,
      input logic [31:0] m, input logic [31:0] x, input logic er);
    exp_q.push_back({m, er, x});
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 32'h0, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(a, 1'b0, 32'h0, m, x, 1'b0);
  endtask

  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 60) begin
      @(posedge mclk);
      n++;
    end
  endtask

  // Result monitor: one note per completed transfer
  always @(posedge mclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check(prdata & e[64:33], e[31:0]);
      check(32'(pslverr), 32'(e[32]));
    end
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    void'($urandom(52));
    foreach (ra[i]) rd(ra[i], 32'hFFFFFFFF, {24'h0, rv[i]});
    foreach (ra[i]) begin
      wv[i] = 8'($urandom());
      wr(ra[i], {24'h0, wv[i]});
      rd(ra[i], 32'hFFFFFFFF, {24'h0, wv[i][7:1], (i == 4) ? 1'b0 : wv[i][0]});
    end
    apb(16'h3C20, 1'b0, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b1);
    apb(16'h3C09, 1'b1, 32'h55, 32'h0, 32'h0, 1'b1);
    rd(16'h3C08, 32'hFF, {24'h0, wv[0]});
    // Continuous mode, reload 0x0003
    wr(16'h3C08, 32'h0);
    wr(16'h3C0C, 32'h3);
    wr(16'h3C18, 32'h0);
    wr(16'h3C44, 32'h1);
    wr(16'h3C1C, 32'h81);
    wait_irq();
    check(32'(irq), 32'h1);
    rd(16'h3C40, 32'h1, 32'h1);
    rd(16'h3C18, 32'h1, 32'h0);
    wr(16'h3C18, 32'h40);
    wr(16'h3C40, 32'h3);
    repeat (30) @(posedge mclk);
    check(32'(irq), 32'h0);
    // Capture from comparator, capture-only interrupts
    wr(16'h3C1C, 32'h0);
    wr(16'h3C08, 32'hFF);
    wr(16'h3C0C, 32'hFF);
    wr(16'h3C18, 32'h50);
    wr(16'h3C40, 32'h3);
    wr(16'h3C1C, 32'h84);
    timer_in_pin <= 1'b1;
    repeat (10) @(posedge mclk);
    check(32'(irq), 32'h0);
    comparator_out <= 1'b1;
    wait_irq();
    check(32'(irq), 32'h1);
    rd(16'h3C18, 32'h1, 32'h1);
    // Dual PWM, dead band code 2
    wr(16'h3C1C, 32'h0);
    wr(16'h3C44, 32'h0);
    wr(16'h3C08, 32'h0);
    wr(16'h3C0C, 32'h20);
    wr(16'h3C10, 32'h0);
    wr(16'h3C14, 32'h10);
    wr(16'h3C18, 32'hC4);
    wr(16'h3C1C, 32'h80);
    seen = 2'h0;
    repeat (150) begin
      @(posedge mclk);
      seen = seen | {timer_pins.out, timer_pins.out_cmp};
    end
    check(32'(seen), 32'h3);
    wr(16'h3C1C, 32'h41);
    repeat (3) @(posedge mclk);
    check(32'(timer_pins), 32'h2);
    tally_and_finish();
  end
endmodule // tb_tmrpw_top

//--- dv/tmrpw_sva.sv
`timescale 1ns/10ps

module tmrpw_sva (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer_in_pin,
  input wire logic comparator_out,
  input tmrpw_pkg::tmrpw_pins_t timer_pins,
  input wire logic irq
);
  logic [3:0] mode_q;
  logic [2:0] code_q;
  logic en_q;
  logic pol_q;
  logic [1:0] msk_q;
  logic [8:0] gap_q;
  logic wr_ok;
  logic mapped;
  int dly;
  assign wr_ok = psel && penable && pwrite && pready;
  assign mapped = paddr inside {16'h3C08, 16'h3C0C, 16'h3C10, 16'h3C14, 16'h3C18,
    16'h3C1C, 16'h3C40, 16'h3C44};
  assign dly = (code_q == 3'h0) ? 0 : (1 << code_q);
  // Shadows of software-only fields; hardware may clear enable, so only en_q==0 is trusted
  always_ff @(posedge mclk) begin
    if (rst) begin
      {mode_q, code_q, en_q, pol_q, msk_q} <= '0;
    end else if (wr_ok && paddr == 16'h3C18) begin
      {mode_q[3], code_q} <= {pwdata[7], pwdata[3:1]};
    end else if (wr_ok && paddr == 16'h3C1C) begin
      {en_q, pol_q, mode_q[2:0]} <= {pwdata[7:6], pwdata[2:0]};
    end else if (wr_ok && paddr == 16'h3C44) begin
      msk_q <= pwdata[1:0];
    end
  end
  // Cycles with both outputs low
  always_ff @(posedge mclk) begin
    if (rst || timer_pins.out || timer_pins.out_cmp) begin
      gap_q <= 9'h000;
    end else if (gap_q != 9'h1FF) begin
      gap_q <= gap_q + 9'h001;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  err_unmapped_a: assert property (psel && penable && !mapped |-> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  err_mapped_a: assert property (psel && penable && mapped |-> !pslverr)
    else $error("mapped access refused");
  rd_width_a: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  cmp_gated_a: assert property (mode_q != 4'h8 |-> !timer_pins.out_cmp)
    else $error("complement active outside dual mode");
  no_overlap_a: assert property (mode_q == 4'h8 |-> !(timer_pins.out && timer_pins.out_cmp))
    else $error("both outputs active");
  idle_pol_a: assert property (!en_q ##1 !en_q |-> timer_pins.out == $past(pol_q))
    else $error("disabled output differs from polarity");
  irq_masked_a: assert property (msk_q == 2'h0 |-> !irq)
    else $error("interrupt with all sources masked");
  deadband_gap_a: assert property (mode_q == 4'h8 && en_q && $rose(timer_pins.out)
    |-> int'(gap_q) >= dly)
    else $error("dead gap too short");
  cover property ($rose(irq));
  cover property (mode_q == 4'h8 && $rose(timer_pins.out));
  cover property (psel && penable && pslverr);
endmodule // tmrpw_sva

bind tmrpw_top tmrpw_sva u_tmrpw_sva (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .timer_in_pin(timer_in_pin), .comparator_out(comparator_out),
  .timer_pins(timer_pins), .irq(irq));

//--- logic/tmrpw_consts.svh
`ifndef TMRPW_CONSTS_SVH
`define TMRPW_CONSTS_SVH

// Register indices; byte address is four times the index
`define TMRPW_IDX_RLD_HI 12'hF02
`define TMRPW_IDX_RLD_LO 12'hF03
`define TMRPW_IDX_MAT_HI 12'hF04
`define TMRPW_IDX_MAT_LO 12'hF05
`define TMRPW_IDX_CTL0 12'hF06
`define TMRPW_IDX_CTL1 12'hF07
`define TMRPW_IDX_STS 12'hF10
`define TMRPW_IDX_MSK 12'hF11

// Reset values
`define TMRPW_RST_RLD 8'hFF
`define TMRPW_RST_MAT 8'h00
`define TMRPW_RST_CTL0 8'h00
`define TMRPW_RST_CTL1 8'h00
`define TMRPW_RST_IRQ 2'h0

// Fields of timer_control_first
`define TMRPW_C0_MODE_HI 7
`define TMRPW_C0_ICFG_MSB 6
`define TMRPW_C0_ICFG_LSB 5
`define TMRPW_C0_INSEL 4
`define TMRPW_C0_DB_MSB 3
`define TMRPW_C0_DB_LSB 1
`define TMRPW_C0_CAPF 0

// Fields of timer_control_second
`define TMRPW_C1_EN 7
`define TMRPW_C1_POL 6
`define TMRPW_C1_PRE_MSB 5
`define TMRPW_C1_PRE_LSB 3
`define TMRPW_C1_MODE_MSB 2
`define TMRPW_C1_MODE_LSB 0

// Interrupt status and mask bits
`define TMRPW_IRQ_TIMER 0
`define TMRPW_IRQ_MATCH 1

// Count value loaded at reload
`define TMRPW_CNT_START 16'h0001

`endif

//--- logic/tmrpw_deadband.sv
`timescale 1ns/10ps
`include "tmrpw_consts.svh"

module tmrpw_deadband (
  input wire logic mclk,
  input wire logic rst,
  input wire logic level,
  input wire logic [2:0] code,
  output logic out
);

  tmrpw_pkg::tmrpw_db_state_t s_q;
  tmrpw_pkg::tmrpw_db_state_t s_d;
  logic [7:0] delay;

  // RL9 delay code decode
  assign delay = (code == 3'h0) ? 8'h00 : 8'(9'h001 << code);

  always_comb begin
    s_d = s_q;
    if (!level) begin
      // RL15 deassertion is never delayed
      s_d.out = 1'b0;
      s_d.cnt = 8'h00;
    end else if (!s_q.out) begin
      // RL8 hold off the assertion
      if (s_q.cnt >= delay) begin
        s_d.out = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign out = s_q.out;

endmodule // tmrpw_deadband

//--- logic/tmrpw_pkg.sv
package tmrpw_pkg;

  typedef enum logic [3:0] {
    TMRPW_ONE_SHOT = 4'h0,
    TMRPW_CONTINUOUS = 4'h1,
    TMRPW_COUNTER = 4'h2,
    TMRPW_PWM_SINGLE = 4'h3,
    TMRPW_CAPTURE = 4'h4,
    TMRPW_COMPARE = 4'h5,
    TMRPW_GATED = 4'h6,
    TMRPW_CAP_CMP = 4'h7,
    TMRPW_PWM_DUAL = 4'h8,
    TMRPW_CAP_RESTART = 4'h9,
    TMRPW_CMP_COUNTER = 4'hA,
    TMRPW_TRIG_ONE_SHOT = 4'hB
  } tmrpw_mode_t;

  typedef struct packed {
    logic out;
    logic out_cmp;
  } tmrpw_pins_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic out;
  } tmrpw_db_state_t;

  typedef struct packed {
    logic [7:0] rld_hi;
    logic [7:0] rld_lo;
    logic [7:0] mat_hi;
    logic [7:0] mat_lo;
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic [1:0] sts;
    logic [1:0] msk;
    logic [15:0] cnt;
    logic [6:0] pre;
    logic in_prev;
    logic out_raw;
    logic armed;
    logic [31:0] rdata;
  } tmrpw_state_t;

endpackage

//--- logic/tmrpw_top.sv
`timescale 1ns/10ps
`include "tmrpw_consts.svh"

// Function
// RL1: Reload value bytes, reset to all ones
// RL2: PWM match bytes, reset to zero
// RL3: Control bit 7 is mode MSB
// RL4: Plain modes: 0x/11 reload interrupt, 10 none
// RL5: Gated mode: reload and/or inactive gate edge
// RL6: Capture modes: reload and/or capture interrupt
// RL7: Input from pin or comparator
// RL8: Deadband delays output assertion after switch
// RL9: Delay code 0 none, else 2^code cycles
// RL10: Read-only flag shows capture caused interrupt
// RL11: Flag updated on every timer interrupt
// RL12: High byte upper, low byte lower
// RL13: Four-bit mode decode of twelve modes
// RL14: Disabled timer output equals polarity bit
// RL15: Dual PWM complement, deadband on rising only

module tmrpw_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_in_pin,
  input wire logic comparator_out,
  output tmrpw_pkg::tmrpw_pins_t timer_pins,
  output logic irq
);

  tmrpw_pkg::tmrpw_state_t s_q;
  tmrpw_pkg::tmrpw_state_t s_d;
  tmrpw_pkg::tmrpw_mode_t mode;
  logic [11:0] idx;
  logic addr_hit;
  logic wr_en;
  logic [1:0] db_level;
  logic [2:0] db_code;
  logic [1:0] db_out;

  function automatic logic reg_known(input logic [15:0] a);
    logic [11:0] i;
    i = a[13:2];
    reg_known = (a[1:0] == 2'h0) && (a[15:14] == 2'h0) &&
      (i == `TMRPW_IDX_RLD_HI || i == `TMRPW_IDX_RLD_LO ||
       i == `TMRPW_IDX_MAT_HI || i == `TMRPW_IDX_MAT_LO ||
       i == `TMRPW_IDX_CTL0 || i == `TMRPW_IDX_CTL1 ||
       i == `TMRPW_IDX_STS || i == `TMRPW_IDX_MSK);
  endfunction

  function automatic logic is_pwm(input tmrpw_pkg::tmrpw_mode_t m);
    is_pwm = (m == tmrpw_pkg::TMRPW_PWM_SINGLE) || (m == tmrpw_pkg::TMRPW_PWM_DUAL);
  endfunction

  function automatic logic is_capture(input tmrpw_pkg::tmrpw_mode_t m);
    is_capture = (m == tmrpw_pkg::TMRPW_CAPTURE) || (m == tmrpw_pkg::TMRPW_CAP_CMP) ||
      (m == tmrpw_pkg::TMRPW_CAP_RESTART);
  endfunction

  function automatic logic is_one_shot(input tmrpw_pkg::tmrpw_mode_t m);
    is_one_shot = (m == tmrpw_pkg::TMRPW_ONE_SHOT) || (m == tmrpw_pkg::TMRPW_TRIG_ONE_SHOT);
  endfunction

  // Last prescaler count before a tick: divide by two to the code
  function automatic logic [6:0] pre_last(input logic [2:0] code);
    pre_last = 7'h7F >> (3'h7 - code);
  endfunction

  // Returns {interrupt, caused by capture}
  function automatic logic [1:0] irq_pick(
    input tmrpw_pkg::tmrpw_mode_t m,
    input logic [1:0] cfg,
    input logic rld,
    input logic cap,
    input logic gate
  );
    logic use_rld;
    logic use_alt;
    use_rld = (cfg != 2'b10);
    use_alt = !(cfg == 2'b11);
    if (m == tmrpw_pkg::TMRPW_GATED) begin
      // RL5 gated selection
      irq_pick = {(use_rld && rld) || (use_alt && gate), 1'b0};
    end else if (is_capture(m)) begin
      // RL6 capture selection, capture named as cause
      irq_pick = {(use_rld && rld) || (use_alt && cap), use_alt && cap};
    end else begin
      // RL4 reload only, code 10 disables
      irq_pick = {use_rld && rld, 1'b0};
    end
  endfunction

  assign idx = paddr[13:2];
  assign addr_hit = reg_known(paddr);
  assign wr_en = psel && penable && pwrite && addr_hit;
  // Every register is a flop, so no wait states
  assign pready = 1'b1;
  // Unknown or misaligned offsets refused, write dropped
  assign pslverr = psel && penable && !addr_hit;
  assign prdata = s_q.rdata;
  // Level interrupt, held until software clears status
  assign irq = |(s_q.sts & s_q.msk);

  // RL3 RL13 mode from both control registers
  assign mode = tmrpw_pkg::tmrpw_mode_t'({s_q.ctl0[`TMRPW_C0_MODE_HI],
    s_q.ctl1[`TMRPW_C1_MODE_MSB:`TMRPW_C1_MODE_LSB]});

  always_comb begin
    logic en;
    logic pol;
    logic tin;
    logic rise;
    logic fall;
    logic act_edge;
    logic gate_ev;
    logic tick;
    logic count_en;
    logic rld_ev;
    logic mat_ev;
    logic cap_ev;
    logic [6:0] pre_lim;
    logic [15:0] rld_val;
    logic [15:0] mat_val;
    logic [1:0] pick;
    logic [1:0] sts_set;
    logic [1:0] sts_clr;
    logic [31:0] rd;
    // Defaults keep every local driven on all paths
    tin = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    act_edge = 1'b0;
    gate_ev = 1'b0;
    tick = 1'b0;
    count_en = 1'b0;
    rld_ev = 1'b0;
    mat_ev = 1'b0;
    cap_ev = 1'b0;
    pre_lim = 7'h00;
    rld_val = 16'h0000;
    mat_val = 16'h0000;
    pick = 2'h0;
    sts_set = 2'h0;
    sts_clr = 2'h0;
    rd = 32'h0000_0000;

    en = s_q.ctl1[`TMRPW_C1_EN];
    pol = s_q.ctl1[`TMRPW_C1_POL];
    s_d = s_q;
    // RL7 input source
    tin = s_q.ctl0[`TMRPW_C0_INSEL] ? comparator_out : timer_in_pin;
    rise = tin && !s_q.in_prev;
    fall = !tin && s_q.in_prev;
    act_edge = pol ? fall : rise;
    // Inactive gate edge ends the counting level
    gate_ev = en && (mode == tmrpw_pkg::TMRPW_GATED) && (pol ? rise : fall);
    pre_lim = pre_last(s_q.ctl1[`TMRPW_C1_PRE_MSB:`TMRPW_C1_PRE_LSB]);
    tick = (s_q.pre == pre_lim);
    // RL12 byte pairing
    rld_val = {s_q.rld_hi, s_q.rld_lo};
    mat_val = {s_q.mat_hi, s_q.mat_lo};
    unique case (mode)
      tmrpw_pkg::TMRPW_COUNTER, tmrpw_pkg::TMRPW_CMP_COUNTER: count_en = act_edge;
      tmrpw_pkg::TMRPW_GATED: count_en = tick && (tin ^ pol);
      tmrpw_pkg::TMRPW_TRIG_ONE_SHOT, tmrpw_pkg::TMRPW_CAP_CMP: count_en = tick && s_q.armed;
      default: count_en = tick;
    endcase
    count_en = count_en && en;
    // Reload outranks a match in the same cycle
    rld_ev = count_en && (s_q.cnt == rld_val);
    mat_ev = count_en && (s_q.cnt == mat_val) && !rld_ev;
    // Capture/compare spends its first edge on arming
    cap_ev = en && act_edge && is_capture(mode) &&
      ((mode != tmrpw_pkg::TMRPW_CAP_CMP) || s_q.armed);
    s_d.in_prev = tin;

    if (!en) begin
      // Prescaler restarts with each enable
      s_d.pre = 7'h00;
      s_d.armed = 1'b0;
      s_d.out_raw = pol;
    end else begin
      s_d.pre = tick ? 7'h00 : s_q.pre + 7'h01;
      if (act_edge) begin
        s_d.armed = 1'b1;
      end
      if (rld_ev) begin
        s_d.cnt = `TMRPW_CNT_START;
      end else if (cap_ev && mode == tmrpw_pkg::TMRPW_CAP_RESTART) begin
        s_d.cnt = `TMRPW_CNT_START;
      end else if (count_en) begin
        s_d.cnt = s_q.cnt + 16'h0001;
      end
      if (is_pwm(mode)) begin
        if (rld_ev) begin
          s_d.out_raw = pol;
        end else if (mat_ev) begin
          s_d.out_raw = !pol;
        end
      end else if (rld_ev) begin
        s_d.out_raw = !s_q.out_raw;
      end
    end

    pick = irq_pick(mode, s_q.ctl0[`TMRPW_C0_ICFG_MSB:`TMRPW_C0_ICFG_LSB], rld_ev, cap_ev,
      gate_ev);
    sts_set = 2'h0;
    sts_set[`TMRPW_IRQ_TIMER] = pick[1];
    sts_set[`TMRPW_IRQ_MATCH] = mat_ev;

    // Register writes
    sts_clr = 2'h0;
    if (wr_en) begin
      unique case (idx)
        // RL1 RL2 byte registers
        `TMRPW_IDX_RLD_HI: s_d.rld_hi = pwdata[7:0];
        `TMRPW_IDX_RLD_LO: s_d.rld_lo = pwdata[7:0];
        `TMRPW_IDX_MAT_HI: s_d.mat_hi = pwdata[7:0];
        `TMRPW_IDX_MAT_LO: s_d.mat_lo = pwdata[7:0];
        // RL10 capture flag not writable
        `TMRPW_IDX_CTL0: s_d.ctl0[7:1] = pwdata[7:1];
        `TMRPW_IDX_CTL1: s_d.ctl1 = pwdata[7:0];
        `TMRPW_IDX_STS: sts_clr = pwdata[1:0];
        `TMRPW_IDX_MSK: s_d.msk = pwdata[1:0];
        default: s_d.msk = s_q.msk;
      endcase
    end
    // New events outrank a same-cycle clear
    s_d.sts = (s_q.sts & ~sts_clr) | sts_set;

    // RL10 RL11 cause of the latest interrupt
    if (pick[1]) begin
      s_d.ctl0[`TMRPW_C0_CAPF] = pick[0];
    end
    // One-shot modes stop themselves after reload
    if (rld_ev && is_one_shot(mode)) begin
      s_d.ctl1[`TMRPW_C1_EN] = 1'b0;
    end

    // Read data latched in the setup phase
    rd = 32'h0000_0000;
    unique case (idx)
      `TMRPW_IDX_RLD_HI: rd[7:0] = s_q.rld_hi;
      `TMRPW_IDX_RLD_LO: rd[7:0] = s_q.rld_lo;
      `TMRPW_IDX_MAT_HI: rd[7:0] = s_q.mat_hi;
      `TMRPW_IDX_MAT_LO: rd[7:0] = s_q.mat_lo;
      `TMRPW_IDX_CTL0: rd[7:0] = s_q.ctl0;
      `TMRPW_IDX_CTL1: rd[7:0] = s_q.ctl1;
      `TMRPW_IDX_STS: rd[1:0] = s_q.sts;
      `TMRPW_IDX_MSK: rd[1:0] = s_q.msk;
      default: rd = 32'h0000_0000;
    endcase
    if (psel && !penable) begin
      s_d.rdata = addr_hit ? rd : 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
      s_q.rld_hi <= `TMRPW_RST_RLD;
      s_q.rld_lo <= `TMRPW_RST_RLD;
      s_q.mat_hi <= `TMRPW_RST_MAT;
      s_q.mat_lo <= `TMRPW_RST_MAT;
      s_q.ctl0 <= `TMRPW_RST_CTL0;
      s_q.ctl1 <= `TMRPW_RST_CTL1;
      s_q.sts <= `TMRPW_RST_IRQ;
      s_q.msk <= `TMRPW_RST_IRQ;
      s_q.cnt <= `TMRPW_CNT_START;
    end else begin
      s_q <= s_d;
    end
  end

  // RL14 disabled output follows polarity; RL15 complement is the inverse
  assign db_level[0] = s_q.ctl1[`TMRPW_C1_EN] ? s_q.out_raw : s_q.ctl1[`TMRPW_C1_POL];
  assign db_level[1] = !db_level[0];
  // RL8 deadband only in PWM modes while running
  assign db_code = (is_pwm(mode) && s_q.ctl1[`TMRPW_C1_EN]) ?
    s_q.ctl0[`TMRPW_C0_DB_MSB:`TMRPW_C0_DB_LSB] : 3'h0;

  // One delay counter per output, each delays only its rise
  for (genvar g = 0; g < 2; g++) begin : g_db
    tmrpw_deadband u_db (
      .mclk(mclk),
      .rst(rst),
      .level(db_level[g]),
      .code(db_code),
      .out(db_out[g])
    );
  end

  assign timer_pins.out = db_out[0];
  // Complement pin only carries a signal in dual PWM
  assign timer_pins.out_cmp = (mode == tmrpw_pkg::TMRPW_PWM_DUAL) ? db_out[1] : 1'b0;

endmodule // tmrpw_top
